// *** src/gso_fifo_if.sv ***
// Interface between the stage control and its hold-back buffer
`timescale 1ns/1ps
interface gso_fifo_if;
	logic push;
	logic [gso_pkg::ENTRY_W-1:0] push_data;
	logic pop;
	logic [gso_pkg::ENTRY_W-1:0] head;
	logic [gso_pkg::FIFO_CNT_W-1:0] fill;
	logic full;
	logic empty;

	modport owner(input push, input push_data, input pop,
		output head, output fill, output full, output empty);
	modport user(output push, output push_data, output pop,
		input head, input fill, input full, input empty);
endinterface : gso_fifo_if

// *** src/gso_hold_buf.sv ***
// Hold-back buffer for vertices of the thread waiting its turn
`timescale 1ns/1ps
module gso_hold_buf (
	input wire logic mclk,
	input wire logic reset_n,
	gso_fifo_if.owner port
);
	logic [gso_pkg::ENTRY_W-1:0] mem [gso_pkg::FIFO_DEPTH];
	logic [gso_pkg::FIFO_CNT_W-2:0] wr_ptr;
	logic [gso_pkg::FIFO_CNT_W-2:0] rd_ptr;
	logic [gso_pkg::FIFO_CNT_W-1:0] fill;

	// ==========================================================
	// Storage array, no reset needed on data
	always_ff @(posedge mclk) begin
		if (port.push) begin
			mem[wr_ptr] <= port.push_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
		end else begin
			if (port.push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (port.pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (port.push && !port.pop) begin
				fill <= fill + 1'b1;
			end else if (port.pop && !port.push) begin
				fill <= fill - 1'b1;
			end
		end
	end

	// Status toward the user
	assign port.head = mem[rd_ptr];
	assign port.fill = fill;
	assign port.full = fill == gso_pkg::FIFO_CNT_W'(gso_pkg::FIFO_DEPTH);
	assign port.empty = fill == '0;

endmodule : gso_hold_buf

// *** src/gso_pkg.sv ***
// Shared constants and types for the geometry stage output and statistics
package gso_pkg;

	// ==========================================================
	// Data widths and depths
	localparam int HDR_W = 32;
	localparam int TAG_W = 4;
	localparam int ENTRY_W = 36;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_CNT_W = 5;
	localparam int PRIM_W = 16;
	localparam int SO_INC_W = 8;
	localparam int CNT_NUM = 4;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_INV = 12'h010;
	localparam logic [11:0] OFS_PRIMS = 12'h014;
	localparam logic [11:0] OFS_SO_WRITTEN = 12'h018;
	localparam logic [11:0] OFS_SO_STORAGE = 12'h01C;

	// ==========================================================
	// Field positions and reset values
	localparam int CTRL_STATS_BIT = 0;
	localparam int CTRL_SO_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int ST_TURN_LSB = 0;
	localparam int ST_DISP_LSB = 8;
	localparam int ST_FILL_LSB = 16;
	localparam logic [31:0] CNT_RESET = 32'h0;

	// ==========================================================
	// Counter indices
	localparam int IDX_INV = 0;
	localparam int IDX_PRIMS = 1;
	localparam int IDX_SO_WRITTEN = 2;
	localparam int IDX_SO_STORAGE = 3;

	// Register select from address decode
	typedef enum logic [2:0] {
		GSO_SEL_CTRL,
		GSO_SEL_STATUS,
		GSO_SEL_INV,
		GSO_SEL_PRIMS,
		GSO_SEL_SO_WRITTEN,
		GSO_SEL_SO_STORAGE,
		GSO_SEL_NONE
	} gso_sel_t;

endpackage : gso_pkg

// *** src/gso_stat_counter.sv ***
// One 32-bit statistics counter with software load
`timescale 1ns/1ps
module gso_stat_counter (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic load,
	input wire logic [31:0] load_value,
	input wire logic [31:0] add,
	output logic [31:0] value
);
	// ==========================================================
	// Load wins over the sum of this cycle
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			value <= gso_pkg::CNT_RESET;
		end else if (load) begin
			value <= load_value;
		end else begin
			value <= value + add;
		end
	end
endmodule : gso_stat_counter

// *** src/gso_top.sv ***
// Geometry stage output ordering, header readback and statistics
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module gso_top (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic dispatch_valid,
	output logic [gso_pkg::TAG_W-1:0] dispatch_tag,
	input wire logic vtx_req,
	input wire logic vtx_pass,
	input wire logic [gso_pkg::TAG_W-1:0] vtx_tag,
	input wire logic [gso_pkg::HDR_W-1:0] vtx_header,
	output logic vtx_ack,
	input wire logic sync_req,
	input wire logic [gso_pkg::TAG_W-1:0] sync_tag,
	input wire logic [gso_pkg::PRIM_W-1:0] sync_prims,
	input wire logic [gso_pkg::PRIM_W-1:0] sync_storage,
	output logic sync_ack,
	input wire logic eot_valid,
	input wire logic [gso_pkg::TAG_W-1:0] eot_tag,
	input wire logic [gso_pkg::SO_INC_W-1:0] eot_so_inc,
	input wire logic svb_valid,
	input wire logic svb_inc_written,
	input wire logic svb_inc_storage,
	output logic clip_valid,
	output logic [gso_pkg::HDR_W-1:0] clip_header,
	input wire logic clip_ready
);
	// ==========================================================
	// Declarations
	logic [1:0] ctrl;
	logic [gso_pkg::TAG_W-1:0] turn;
	logic [gso_pkg::TAG_W-1:0] turn_next_tag;
	logic [(1<<gso_pkg::TAG_W)-1:0] done;
	logic [(1<<gso_pkg::TAG_W)-1:0] next_done;
	logic threads_live;
	logic head_turn;
	logic clip_free;
	logic take_direct;
	logic take_buffer;
	logic take_pass;
	logic drain;
	logic advance;
	logic sync_grant;
	logic stats_en;
	logic so_en;
	logic wr_fire;
	gso_pkg::gso_sel_t sel;
	logic [31:0] rd_word;
	logic [31:0] cnt_val [gso_pkg::CNT_NUM];
	logic [31:0] cnt_add [gso_pkg::CNT_NUM];
	logic cnt_load [gso_pkg::CNT_NUM];
	gso_fifo_if hold();

	// Address decode shared by read and write paths
	function automatic gso_pkg::gso_sel_t decode(input logic [11:0] addr);
		case (addr)
			gso_pkg::OFS_CTRL: decode = gso_pkg::GSO_SEL_CTRL;
			gso_pkg::OFS_STATUS: decode = gso_pkg::GSO_SEL_STATUS;
			gso_pkg::OFS_INV: decode = gso_pkg::GSO_SEL_INV;
			gso_pkg::OFS_PRIMS: decode = gso_pkg::GSO_SEL_PRIMS;
			gso_pkg::OFS_SO_WRITTEN: decode = gso_pkg::GSO_SEL_SO_WRITTEN;
			gso_pkg::OFS_SO_STORAGE: decode = gso_pkg::GSO_SEL_SO_STORAGE;
			default: decode = gso_pkg::GSO_SEL_NONE;
		endcase
	endfunction : decode

	// ==========================================================
	// APB slave
	assign sel = decode(paddr);
	assign wr_fire = psel && penable && pready && pwrite;
	assign stats_en = ctrl[gso_pkg::CTRL_STATS_BIT];
	assign so_en = ctrl[gso_pkg::CTRL_SO_BIT];

	// Read mux
	always_comb begin
		rd_word = 32'h0;
		case (sel)
			gso_pkg::GSO_SEL_CTRL: rd_word = {30'h0, ctrl};
			gso_pkg::GSO_SEL_STATUS: begin
				rd_word[gso_pkg::ST_TURN_LSB +: gso_pkg::TAG_W] = turn;
				rd_word[gso_pkg::ST_DISP_LSB +: gso_pkg::TAG_W] = dispatch_tag;
				rd_word[gso_pkg::ST_FILL_LSB +: gso_pkg::FIFO_CNT_W] = hold.fill;
			end
			gso_pkg::GSO_SEL_INV: rd_word = cnt_val[gso_pkg::IDX_INV];
			gso_pkg::GSO_SEL_PRIMS: rd_word = cnt_val[gso_pkg::IDX_PRIMS];
			gso_pkg::GSO_SEL_SO_WRITTEN:
				rd_word = cnt_val[gso_pkg::IDX_SO_WRITTEN];
			gso_pkg::GSO_SEL_SO_STORAGE:
				rd_word = cnt_val[gso_pkg::IDX_SO_STORAGE];
			default: rd_word = 32'h0;
		endcase
	end

	// One wait-free access: answer set up in the setup cycle
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable && !pready;
			if (psel && !penable) begin
				prdata <= pwrite ? 32'h0 : rd_word;
				pslverr <= sel == gso_pkg::GSO_SEL_NONE;
			end
		end
	end

	// Control register
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= gso_pkg::CTRL_RESET;
		end else if (wr_fire && sel == gso_pkg::GSO_SEL_CTRL) begin
			ctrl <= pwdata[1:0];
		end
	end

	// ==========================================================
	// Statistics counters
	always_comb begin
		cnt_add[gso_pkg::IDX_INV] = 32'(dispatch_valid && stats_en);
		cnt_add[gso_pkg::IDX_PRIMS] = sync_grant ? 32'(sync_prims) : 32'h0;
		// Streamed and end-of-thread bumps summed, gated by so_en
		cnt_add[gso_pkg::IDX_SO_WRITTEN] = so_en ?
			32'(svb_valid && svb_inc_written) +
			(eot_valid ? 32'(eot_so_inc) : 32'h0) : 32'h0;
		cnt_add[gso_pkg::IDX_SO_STORAGE] =
			(so_en ? 32'(svb_valid && svb_inc_storage) : 32'h0) +
			(sync_grant ? 32'(sync_storage) : 32'h0);
	end

	// Four counters, each loadable at its own offset
	genvar gi;
	generate
		for (gi = 0; gi < gso_pkg::CNT_NUM; gi++) begin : g_cnt
			assign cnt_load[gi] = wr_fire &&
				sel == gso_pkg::gso_sel_t'(gi + 2);
			gso_stat_counter u_cnt (
				.mclk(mclk),
				.reset_n(reset_n),
				.load(cnt_load[gi]),
				.load_value(pwdata),
				.add(cnt_add[gi]),
				.value(cnt_val[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Thread ordering
	assign turn_next_tag = turn + 1'b1;
	assign threads_live = dispatch_tag != turn;
	assign head_turn = !hold.empty &&
		hold.head[gso_pkg::ENTRY_W-1 -: gso_pkg::TAG_W] == turn;
	assign clip_free = !clip_valid || clip_ready;
	assign drain = head_turn && clip_free;
	assign take_direct = vtx_req && !vtx_ack && !vtx_pass && threads_live &&
		vtx_tag == turn && !head_turn && clip_free;
	assign take_buffer = vtx_req && !vtx_ack && !vtx_pass &&
		vtx_tag == turn_next_tag && turn_next_tag != dispatch_tag &&
		!hold.full;
	assign take_pass = vtx_req && !vtx_ack && vtx_pass && !threads_live &&
		hold.empty && clip_free;
	assign advance = threads_live && done[turn] && !head_turn;
	assign sync_grant = sync_req && !sync_ack && threads_live &&
		sync_tag == turn;

	// Buffer hookup
	assign hold.push = take_buffer;
	assign hold.push_data = {vtx_tag, vtx_header};
	assign hold.pop = drain;

	// Termination flags: a new end-of-thread wins over the clear
	always_comb begin
		next_done = done;
		if (advance) begin
			next_done[turn] = 1'b0;
		end
		if (eot_valid) begin
			next_done[eot_tag] = 1'b1;
		end
	end

	// Turn, dispatch tag and termination state
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			turn <= '0;
			dispatch_tag <= '0;
			done <= '0;
		end else begin
			done <= next_done;
			if (advance) begin
				turn <= turn_next_tag;
			end
			if (dispatch_valid) begin
				dispatch_tag <= dispatch_tag + 1'b1;
			end
		end
	end

	// Handshake answers toward threads
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			vtx_ack <= 1'b0;
			sync_ack <= 1'b0;
		end else begin
			vtx_ack <= take_direct || take_buffer || take_pass;
			sync_ack <= sync_grant;
		end
	end

	// Header readback register toward clip
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			clip_valid <= 1'b0;
			clip_header <= '0;
		end else if (drain) begin
			clip_valid <= 1'b1;
			clip_header <= hold.head[gso_pkg::HDR_W-1:0];
		end else if (take_direct || take_pass) begin
			clip_valid <= 1'b1;
			clip_header <= vtx_header;
		end else if (clip_ready) begin
			clip_valid <= 1'b0;
		end
	end

	gso_hold_buf u_hold (
		.mclk(mclk),
		.reset_n(reset_n),
		.port(hold)
	);

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	hdr_forward_a: assert property (take_direct |=> clip_valid &&
		clip_header == $past(vtx_header))
		else $error("direct header not forwarded");
	drain_order_a: assert property (drain |=> clip_valid &&
		clip_header == $past(hold.head[gso_pkg::HDR_W-1:0]))
		else $error("held header not forwarded");
	clip_hold_a: assert property (clip_valid && !clip_ready |=>
		clip_valid && $stable(clip_header))
		else $error("clip output changed while stalled");
	sync_turn_a: assert property (sync_ack |->
		$past(sync_tag) == $past(turn) && $past(threads_live))
		else $error("sync reply outside thread turn");
	inv_count_a: assert property (!cnt_load[gso_pkg::IDX_INV] |=>
		cnt_val[gso_pkg::IDX_INV] == $past(cnt_val[gso_pkg::IDX_INV]) +
		32'($past(dispatch_valid && stats_en)))
		else $error("invocation count wrong");
	prims_count_a: assert property (sync_grant &&
		!cnt_load[gso_pkg::IDX_PRIMS] |=> cnt_val[gso_pkg::IDX_PRIMS] ==
		$past(cnt_val[gso_pkg::IDX_PRIMS]) + 32'($past(sync_prims)))
		else $error("generated count wrong");
	so_gate_a: assert property (!so_en && !eot_valid &&
		!cnt_load[gso_pkg::IDX_SO_WRITTEN] |=> $stable(cnt_val[2]))
		else $error("written count moved while disabled");
	so_written_a: assert property (so_en && svb_valid &&
		svb_inc_written && !eot_valid && !cnt_load[2] |=>
		cnt_val[2] == $past(cnt_val[2]) + 32'h1)
		else $error("written count missed bump");
	storage_sum_a: assert property (!cnt_load[3] |=>
		cnt_val[3] == $past(cnt_val[3]) + 32'($past(so_en && svb_valid &&
		svb_inc_storage)) + ($past(sync_grant) ?
		32'($past(sync_storage)) : 32'h0))
		else $error("storage count wrong");
	apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("apb answer timing wrong");

endmodule : gso_top

// *** tb/gso_clip_model.sv ***
// Downstream clip stage model that logs accepted vertex headers
`timescale 1ns/1ps
module gso_clip_model (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic slow,
	input wire logic clip_valid,
	input wire logic [gso_pkg::HDR_W-1:0] clip_header,
	output logic clip_ready
);
	logic [gso_pkg::HDR_W-1:0] got[$];

	// ==========================================================
	// Ready handshake
	// Stall every other cycle when slow, to test the hold at the clip port
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			clip_ready <= 1'h0;
		end else begin
			clip_ready <= slow ? ~clip_ready : 1'h1;
		end
	end

	// Log each header taken, in arrival order
	always @(posedge mclk) begin
		if (reset_n && clip_valid && clip_ready) begin
			got.push_back(clip_header);
		end
	end
endmodule : gso_clip_model

// *** tb/gso_top_tb.sv ***
// Self-checking testbench for the geometry stage output block
`timescale 1ns/1ps
module gso_top_tb;
	logic mclk = 1'h0;
	logic reset_n = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic dispatch_valid = 1'h0;
	logic [3:0] dispatch_tag;
	logic vtx_req = 1'h0;
	logic vtx_pass = 1'h0;
	logic [3:0] vtx_tag = 4'h0;
	logic [31:0] vtx_header = 32'h0;
	logic vtx_ack;
	logic sync_req = 1'h0;
	logic [3:0] sync_tag = 4'h0;
	logic [15:0] sync_prims = 16'h0;
	logic [15:0] sync_storage = 16'h0;
	logic sync_ack;
	logic eot_valid = 1'h0;
	logic [3:0] eot_tag = 4'h0;
	logic [7:0] eot_so_inc = 8'h0;
	logic svb_valid = 1'h0;
	logic svb_inc_written = 1'h0;
	logic svb_inc_storage = 1'h0;
	logic clip_valid;
	logic [31:0] clip_header;
	logic clip_ready;
	logic slow = 1'h0;
	int n_mismatch = 0;
	int n_tests = 0;

	// ==========================================================
	// Clock, design and clip model
	always #4 mclk = ~mclk;

	gso_top gso_top_i (.mclk(mclk), .reset_n(reset_n), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dispatch_valid(dispatch_valid), .dispatch_tag(dispatch_tag),
		.vtx_req(vtx_req), .vtx_pass(vtx_pass), .vtx_tag(vtx_tag),
		.vtx_header(vtx_header), .vtx_ack(vtx_ack), .sync_req(sync_req),
		.sync_tag(sync_tag), .sync_prims(sync_prims),
		.sync_storage(sync_storage), .sync_ack(sync_ack),
		.eot_valid(eot_valid), .eot_tag(eot_tag), .eot_so_inc(eot_so_inc),
		.svb_valid(svb_valid), .svb_inc_written(svb_inc_written),
		.svb_inc_storage(svb_inc_storage), .clip_valid(clip_valid),
		.clip_header(clip_header), .clip_ready(clip_ready));

	gso_clip_model gso_clip_model_i (.mclk(mclk), .reset_n(reset_n),
		.slow(slow), .clip_valid(clip_valid), .clip_header(clip_header),
		.clip_ready(clip_ready));

	// ==========================================================
	// Report and compare
	task automatic print_verdict;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic timeout;
		n_mismatch++;
		$display("[ERR] %0t wait ran out", $time);
		print_verdict();
	endtask : timeout

	// ==========================================================
	// Bus and message drivers
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		int i;
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		// Hold the request until pready is seen high at a rising edge
		for (i = 0; i < 20; i++) begin
			@(posedge mclk);
			if (pready === 1'h1) break;
		end
		if (i == 20) timeout();
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		pwdata <= ~d;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'h1, a, d, r, e);
	endtask : wr

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'h0, a, 32'h0, r, e);
		cmp(r, exp);
	endtask : rd_chk

	task automatic disp(input int n);
		repeat (n) begin
			@(posedge mclk);
			dispatch_valid <= 1'h1;
			@(posedge mclk);
			dispatch_valid <= 1'h0;
		end
	endtask : disp

	// Streamed write and end-of-thread write, in the same cycle
	task automatic so_msg(input logic w, input logic s, input logic end_of_thread_flag,
		input logic [3:0] tag, input logic [7:0] inc);
		@(posedge mclk);
		svb_valid <= w | s;
		svb_inc_written <= w;
		svb_inc_storage <= s;
		eot_valid <= end_of_thread_flag;
		eot_tag <= tag;
		eot_so_inc <= inc;
		@(posedge mclk);
		svb_valid <= 1'h0;
		svb_inc_written <= ~w;
		svb_inc_storage <= ~s;
		eot_valid <= 1'h0;
		eot_tag <= ~tag;
		eot_so_inc <= ~inc;
	endtask : so_msg

	task automatic vtx(input logic pass, input logic [3:0] tag,
		input logic [31:0] h);
		int i;
		@(posedge mclk);
		vtx_req <= 1'h1;
		vtx_pass <= pass;
		vtx_tag <= tag;
		vtx_header <= h;
		// Vertex stands until vtx_ack is seen high at a rising edge
		for (i = 0; i < 40; i++) begin
			@(posedge mclk);
			if (vtx_ack === 1'h1) break;
		end
		if (i == 40) timeout();
		vtx_req <= 1'h0;
		vtx_pass <= ~pass;
		vtx_tag <= ~tag;
		vtx_header <= ~h;
	endtask : vtx

	task automatic sync(input logic [3:0] tag, input logic [15:0] p,
		input logic [15:0] s, input int lim, output logic ok);
		@(posedge mclk);
		sync_req <= 1'h1;
		sync_tag <= tag;
		sync_prims <= p;
		sync_storage <= s;
		ok = 1'h0;
		// Message stands until sync_ack is seen high at a rising edge, or for at most lim edges
		for (int i = 0; i < lim && !ok; i++) begin
			@(posedge mclk);
			ok = (sync_ack === 1'h1);
		end
		sync_req <= 1'h0;
		sync_tag <= ~tag;
		sync_prims <= ~p;
		sync_storage <= ~s;
	endtask : sync

	// ==========================================================
	// Scenarios
	task automatic t_stats;
		logic [31:0] r;
		logic e;
		rd_chk(gso_pkg::OFS_CTRL, 32'h0);
		apb(1'h0, 12'h020, 32'h0, r, e);
		cmp({31'h0, e}, 32'h1);
		disp(1);
		rd_chk(gso_pkg::OFS_INV, 32'h0);
		wr(gso_pkg::OFS_CTRL, 32'h1);
		disp(2);
		rd_chk(gso_pkg::OFS_INV, 32'h2);
		so_msg(1'h1, 1'h1, 1'h0, 4'h0, 8'h0);
		rd_chk(gso_pkg::OFS_SO_WRITTEN, 32'h0);
		rd_chk(gso_pkg::OFS_SO_STORAGE, 32'h0);
		wr(gso_pkg::OFS_CTRL, 32'h2);
		so_msg(1'h1, 1'h1, 1'h0, 4'h0, 8'h0);
		rd_chk(gso_pkg::OFS_SO_WRITTEN, 32'h1);
		rd_chk(gso_pkg::OFS_SO_STORAGE, 32'h1);
		so_msg(1'h1, 1'h0, 1'h1, 4'h0, 8'h04);
		rd_chk(gso_pkg::OFS_SO_WRITTEN, 32'h6);
		// Software load, then a bump that wraps with no clamp
		wr(gso_pkg::OFS_SO_WRITTEN, 32'hFFFF_FFFF);
		rd_chk(gso_pkg::OFS_SO_WRITTEN, 32'hFFFF_FFFF);
		so_msg(1'h1, 1'h0, 1'h0, 4'h0, 8'h0);
		rd_chk(gso_pkg::OFS_SO_WRITTEN, 32'h0);
	endtask : t_stats

	task automatic t_sync;
		logic ok;
		sync(4'h2, 16'h0009, 16'h0009, 6, ok);
		cmp({31'h0, ok}, 32'h0);
		sync(4'h1, 16'h0005, 16'h0007, 20, ok);
		cmp({31'h0, ok}, 32'h1);
		rd_chk(gso_pkg::OFS_PRIMS, 32'h5);
		rd_chk(gso_pkg::OFS_SO_STORAGE, 32'h8);
	endtask : t_sync

	task automatic t_order;
		logic [31:0] exp[3];
		exp = '{32'hA0A0_0001, 32'hB0B0_0002, 32'hC0C0_0003};
		slow <= 1'h1;
		vtx(1'h0, 4'h2, exp[1]);
		rd_chk(gso_pkg::OFS_STATUS, 32'h0001_0301);
		vtx(1'h0, 4'h1, exp[0]);
		so_msg(1'h0, 1'h0, 1'h1, 4'h1, 8'h0);
		so_msg(1'h0, 1'h0, 1'h1, 4'h2, 8'h0);
		vtx(1'h1, 4'h0, exp[2]);
		repeat (10) @(posedge mclk);
		cmp(gso_clip_model_i.got.size(), 32'h3);
		for (int k = 0; k < 3 && k < gso_clip_model_i.got.size(); k++) begin
			cmp(gso_clip_model_i.got[k], exp[k]);
		end
		rd_chk(gso_pkg::OFS_STATUS, 32'h0000_0303);
	endtask : t_order

	// ==========================================================
	// Main sequence
	initial begin
		repeat (10) @(posedge mclk);
		reset_n <= 1'h1;
		t_stats();
		t_sync();
		t_order();
		print_verdict();
	end
endmodule : gso_top_tb
